/* File: rtl/pin_cell.sv */
// Purpose: one pin of a port: port bit or control function
// Assumes: dir 1 means input, ctl 1 means control mode
// Notes: pin input passes two flops before use
module pin_cell
(
    input wire logic clock,
    input wire logic srst,
    input wire logic dir,
    input wire logic pu_en,
    input wire logic ctl,
    input wire logic lat,
    input wire logic per_oe,
    input wire logic per_out,
    input wire logic od,
    input wire logic hiz,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_pu,
    output logic pin_sync
);
    // registered state of the cell
    typedef struct packed {
        logic s1;
        logic s2;
        logic o;
        logic e;
        logic p;
    } cell_t;
    cell_t q, d;
    logic val;
    logic drv;
    // next state: sync chain and pad drive
    always_comb
    begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        val = (ctl && per_oe) ? per_out : lat;
        drv = ctl ? per_oe : ~dir;
        if (hiz)
        begin
            drv = 1'b0;
        end
        if (od && val)
        begin
            drv = 1'b0;
        end
        d.o = val;
        d.e = drv;
        // pull-up only on an input port bit
        d.p = pu_en && dir && !ctl;
        if (srst)
        begin
            d = '0;
            // sync chain keeps tracking the pad so no false edge follows reset
            d.s1 = pin_in;
            d.s2 = q.s1;
        end
    end
    // state register
    always_ff @(posedge clock)
    begin
        q <= d;
    end
    assign pin_out = q.o;
    assign pin_oe = q.e;
    assign pin_pu = q.p;
    assign pin_sync = q.s2;
endmodule

/* File: rtl/port_mux_cfg.svh */
// Purpose: reset values and widths for the port pin function mux
// Assumes: included by bare name from the package
// Notes: definitions only
`ifndef PORT_MUX_CFG_SVH
`define PORT_MUX_CFG_SVH
`define P1_W 4
`define P2_W 8
`define P3_W 3
`define P4_W 2
`define P5_W 3
`define DIR_RST_P1 4'hF
`define DIR_RST_P2 8'hFF
`define DIR_RST_P3 3'h7
`define DIR_RST_P4 2'h3
`define DIR_RST_P5 3'h7
`define PU_RST_P1 4'h0
`define PU_RST_P3 3'h0
`define PU_RST_P4 2'h0
`define PU_RST_P5 3'h0
`define CTL_RST_P1 4'h0
`define CTL_RST_P2 8'h00
`define CTL_RST_P3 3'h0
`define CTL_RST_P4 2'h0
`define CTL_RST_P5 3'h0
`define PIM_RST_P3 2'h0
`define POM_RST_P3 3'h0
`define LAT_RST_8 8'h00
`endif

/* File: rtl/port_mux_pkg.sv */
// Purpose: shared types for the port pin function mux
// Assumes: port_mux_cfg.svh supplies widths
// Notes: only types live here
`include "port_mux_cfg.svh"
package port_mux_pkg;
    // drive of one pin: value, enable, pull-up
    typedef struct packed {
        logic out;
        logic oe;
        logic pu;
    } pin_drive_t;
    // debug attachment of the tool pins
    typedef enum logic [2:0] {
        DBG_OFF = 3'h1,
        DBG_ONE = 3'h2,
        DBG_TWO = 3'h4
    } dbg_mode_t;
    // per-port software settings
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] pu;
        logic [7:0] ctl;
        logic [7:0] lat;
    } port_cfg_t;
endpackage

/* File: rtl/port_pin_function_mux.sv */
// Purpose: pin multiplexing for ports 1 to 5
// Assumes: settings come on plain ports, one 20 MHz clock
// Notes: dir bit 1 is input; ctl bit 1 selects control mode
module port_pin_function_mux
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] port1_direction_reg,
    input wire logic [3:0] port1_pullup_reg,
    input wire logic [3:0] port1_ctl,
    input wire logic [3:0] port1_latch,
    input wire logic [7:0] port2_direction_reg,
    input wire logic [7:0] port2_ctl,
    input wire logic [7:0] port2_latch,
    input wire logic [2:0] port3_direction_reg,
    input wire logic [2:0] port3_pullup_reg,
    input wire logic [2:0] port3_ctl,
    input wire logic [2:0] port3_latch,
    input wire logic [1:0] port3_input_buffer_sel,
    input wire logic [2:0] port3_open_drain_sel,
    input wire logic [1:0] port4_direction_reg,
    input wire logic [1:0] port4_pullup_reg,
    input wire logic [1:0] port4_ctl,
    input wire logic [1:0] port4_latch,
    input wire logic [2:0] port5_direction_reg,
    input wire logic [2:0] port5_pullup_reg,
    input wire logic [2:0] port5_ctl,
    input wire logic [2:0] port5_latch,
    input wire logic [3:0] timer_ch2_out,
    input wire logic [3:0] timer_ch2_oe,
    input wire logic [1:0] timer_ch6_out,
    input wire logic [1:0] timer_ch6_oe,
    input wire logic timer_ch11_out,
    input wire logic csi_data_out,
    input wire logic csi_clock_out,
    input wire logic csi_clock_oe,
    input wire logic uart_b_transmit,
    input wire logic uart_b_sel,
    input wire logic simple_i2c_data_out,
    input wire logic simple_i2c_clock_out,
    input wire logic i2c_sel,
    input wire logic timer_ch11_sel,
    input wire logic [1:0] irq_edge_sel_a,
    input wire logic [1:0] irq_edge_sel_b,
    input wire logic debug_enable_option_bit,
    input wire logic debug_active,
    input wire logic debug_two_line,
    input wire logic tool_data_out,
    input wire logic tool_data_oe,
    input wire logic debug_clock_out,
    input wire logic timer_hiz_ctrl_in_a,
    input wire logic timer_hiz_ctrl_in_b,
    input wire logic flash_prog_mode_pin,
    input wire logic [3:0] p1_pin_in,
    input wire logic [7:0] p2_pin_in,
    input wire logic [2:0] p3_pin_in,
    input wire logic [1:0] p4_pin_in,
    input wire logic [2:0] p5_pin_in,
    output logic [3:0] p1_pin_out,
    output logic [3:0] p1_pin_oe,
    output logic [3:0] p1_pin_pu,
    output logic [7:0] p2_pin_out,
    output logic [7:0] p2_pin_oe,
    output logic [7:0] p2_analog_en,
    output logic [2:0] p3_pin_out,
    output logic [2:0] p3_pin_oe,
    output logic [2:0] p3_pin_pu,
    output logic [1:0] p3_ttl_en,
    output logic [1:0] p4_pin_out,
    output logic [1:0] p4_pin_oe,
    output logic [1:0] p4_pin_pu,
    output logic [2:0] p5_pin_out,
    output logic [2:0] p5_pin_oe,
    output logic [2:0] p5_pin_pu,
    output logic [3:0] timer_ch2_ext_in,
    output logic [1:0] timer_ch6_ext_in,
    output logic timer_ch9_ext_in,
    output logic csi_data_in,
    output logic csi_clock_in,
    output logic uart_b_receive,
    output logic simple_i2c_data_in,
    output logic simple_i2c_clock_in,
    output logic ext_irq_in_a,
    output logic ext_irq_in_b,
    output logic flash_prog_mode,
    output logic [7:0] port2_read,
    output logic [3:0] port1_read,
    output logic [2:0] port3_read,
    output logic [1:0] port4_read,
    output logic [2:0] port5_read
);
    // flat vectors of all 20 pins: p1 0-3, p2 4-11, p3 12-14, p4 15-16, p5 17-19
    localparam int NPIN = 20;
    logic [NPIN-1:0] a_dir, a_pu, a_ctl, a_lat, a_poe, a_pout, a_od, a_hiz;
    logic [NPIN-1:0] a_in, a_out, a_oe, a_pup, a_sync;
    port_mux_pkg::dbg_mode_t dbg_mode;
    logic hiz_a_s1, hiz_b_s1;
    logic fl_s1;

    // registered state of the top
    typedef struct packed {
        logic hiz_a_s2;
        logic hiz_b_s2;
        logic fl_s2;
        logic [1:0] irq_prev;
        logic irq_a;
        logic irq_b;
        logic [7:0] ana;
        logic [1:0] ttl;
        logic [NPIN-1:0] in_q;
    } top_t;
    top_t q, d;

    // debug mode decode
    always_comb
    begin
        case ({debug_active, debug_two_line})
            2'b10: dbg_mode = port_mux_pkg::DBG_ONE;
            2'b11: dbg_mode = port_mux_pkg::DBG_TWO;
            default: dbg_mode = port_mux_pkg::DBG_OFF;
        endcase
    end

    // per-pin setting vectors
    always_comb
    begin
        a_dir[3:0] = port1_direction_reg;
        a_pu[3:0] = port1_pullup_reg;
        a_lat[3:0] = port1_latch;
        a_ctl[3:0] = port1_ctl;
        a_poe[3:0] = timer_ch2_oe;
        a_pout[3:0] = timer_ch2_out;
        // port 2 settings, input only in control
        a_dir[11:4] = port2_direction_reg;
        a_pu[11:4] = 8'h00;
        a_ctl[11:4] = port2_ctl;
        a_lat[11:4] = port2_latch;
        a_poe[11:4] = 8'h00;
        a_pout[11:4] = 8'h00;
        a_dir[14:12] = port3_direction_reg;
        a_pu[14:12] = port3_pullup_reg;
        a_ctl[14:12] = port3_ctl;
        a_lat[14:12] = port3_latch;
        // bit 0: csi data, uart transmit or timer 11
        a_poe[12] = 1'b1;
        a_pout[12] = timer_ch11_sel ? timer_ch11_out : (uart_b_sel ? uart_b_transmit : csi_data_out);
        // bit 1: i2c data, else input only
        a_poe[13] = i2c_sel;
        a_pout[13] = simple_i2c_data_out;
        // bit 2: csi clock or i2c clock
        a_poe[14] = i2c_sel | csi_clock_oe;
        a_pout[14] = i2c_sel ? simple_i2c_clock_out : csi_clock_out;
        a_dir[16:15] = port4_direction_reg;
        a_pu[16:15] = port4_pullup_reg;
        a_lat[16:15] = port4_latch;
        // tool data takes bit 0 while debugging or programming
        a_ctl[15] = port4_ctl[0] | debug_active | q.fl_s2;
        a_poe[15] = tool_data_oe;
        a_pout[15] = tool_data_out;
        // bit 1 is debug clock only in two-line mode
        a_ctl[16] = port4_ctl[1] | (dbg_mode == port_mux_pkg::DBG_TWO);
        a_poe[16] = (dbg_mode == port_mux_pkg::DBG_TWO);
        // debug clock out on port 4 bit 1
        a_pout[16] = debug_clock_out;
        a_dir[19:17] = port5_direction_reg;
        a_pu[19:17] = port5_pullup_reg;
        a_ctl[19:17] = port5_ctl;
        a_lat[19:17] = port5_latch;
        a_poe[19:17] = {1'b0, timer_ch6_oe};
        a_pout[19:17] = {1'b0, timer_ch6_out};
        a_od = '0;
        a_od[14:12] = port3_open_drain_sel;
        // hi-z: a on ports 1 and 3 timers, b on port 5 timers
        a_hiz = '0;
        a_hiz[3:0] = {4{q.hiz_a_s2}} & port1_ctl;
        a_hiz[12] = q.hiz_a_s2 & timer_ch11_sel & port3_ctl[0];
        a_hiz[18:17] = {2{q.hiz_b_s2}} & port5_ctl[1:0];
        a_in = {p5_pin_in, p4_pin_in, p3_pin_in, p2_pin_in, p1_pin_in};
    end

    // one cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_pin
            pin_cell u_cell
            (
                .clock(clock),
                .srst(srst),
                .dir(a_dir[gi]),
                .pu_en(a_pu[gi]),
                .ctl(a_ctl[gi]),
                .lat(a_lat[gi]),
                .per_oe(a_poe[gi]),
                .per_out(a_pout[gi]),
                .od(a_od[gi]),
                .hiz(a_hiz[gi]),
                .pin_in(a_in[gi]),
                .pin_out(a_out[gi]),
                .pin_oe(a_oe[gi]),
                .pin_pu(a_pup[gi]),
                .pin_sync(a_sync[gi])
            );
        end
    endgenerate

    // first sync stage for asynchronous control pins
    always_ff @(posedge clock)
    begin
        hiz_a_s1 <= timer_hiz_ctrl_in_a;
        hiz_b_s1 <= timer_hiz_ctrl_in_b;
        fl_s1 <= flash_prog_mode_pin;
    end

    // next state of the top
    always_comb
    begin
        d = q;
        d.hiz_a_s2 = hiz_a_s1;
        d.hiz_b_s2 = hiz_b_s1;
        d.fl_s2 = fl_s1;
        d.in_q = a_sync;
        // edge detect on interrupt inputs, 01 rise 10 fall 11 both
        d.irq_prev = {a_sync[14], a_sync[13]};
        d.irq_a = (irq_edge_sel_a[0] & a_sync[13] & ~q.irq_prev[0])
                | (irq_edge_sel_a[1] & ~a_sync[13] & q.irq_prev[0]);
        d.irq_b = (irq_edge_sel_b[0] & a_sync[14] & ~q.irq_prev[1])
                | (irq_edge_sel_b[1] & ~a_sync[14] & q.irq_prev[1]);
        d.ana = port2_ctl;
        // ttl buffer select on bits 0 and 1
        d.ttl = port3_input_buffer_sel;
        if (srst)
        begin
            d = '0;
            // edge history follows the pins so release makes no false edge
            d.irq_prev = {a_sync[14], a_sync[13]};
        end
    end

    // state register
    always_ff @(posedge clock)
    begin
        q <= d;
    end

    // pad outputs from cell flops, analog and ttl enables from top flops
    assign p1_pin_out = a_out[3:0];
    assign p1_pin_oe = a_oe[3:0];
    assign p1_pin_pu = a_pup[3:0];
    assign p2_pin_out = a_out[11:4];
    assign p2_pin_oe = a_oe[11:4];
    assign p2_analog_en = q.ana;
    assign p3_pin_out = a_out[14:12];
    assign p3_pin_oe = a_oe[14:12];
    assign p3_pin_pu = a_pup[14:12];
    assign p3_ttl_en = q.ttl;
    // bit 0 stays a port pin when not debugging, not programming and port4_ctl[0] is clear
    assign p4_pin_out = a_out[16:15];
    assign p4_pin_oe = a_oe[16:15];
    assign p4_pin_pu = a_pup[16:15];
    assign p5_pin_out = a_out[19:17];
    assign p5_pin_oe = a_oe[19:17];
    assign p5_pin_pu = a_pup[19:17];
    assign timer_ch2_ext_in = q.in_q[3:0];
    assign timer_ch6_ext_in = q.in_q[18:17];
    assign timer_ch9_ext_in = q.in_q[13];
    assign csi_data_in = q.in_q[13];
    assign csi_clock_in = q.in_q[14];
    assign uart_b_receive = q.in_q[13];
    assign simple_i2c_data_in = q.in_q[13];
    assign simple_i2c_clock_in = q.in_q[14];
    assign ext_irq_in_a = q.irq_a;
    assign ext_irq_in_b = q.irq_b;
    assign flash_prog_mode = q.fl_s2;
    assign port1_read = q.in_q[3:0];
    assign port2_read = q.in_q[11:4];
    assign port3_read = q.in_q[14:12];
    assign port4_read = q.in_q[16:15];
    assign port5_read = q.in_q[19:17];

    p2_digital_rst_a: assert property (
        @(posedge clock) srst |=> p2_analog_en == 8'h00)
        else $error("port 2 analog after reset");
    // two-line mode claims bit 1, one cycle behind the debug clock
    dbg_clk_a: assert property (
        @(posedge clock) disable iff (srst)
        (debug_active && debug_two_line) |=> p4_pin_oe[1] && p4_pin_out[1] == $past(debug_clock_out))
        else $error("debug clock not on port 4 bit 1");
    od_low_a: assert property (
        @(posedge clock) disable iff (srst)
        p3_pin_oe[0] && $past(port3_open_drain_sel[0]) |-> !p3_pin_out[0])
        else $error("open drain drove high");
    hiz_off_a: assert property (
        @(posedge clock) disable iff (srst)
        $past(q.hiz_b_s2) && $past(port5_ctl[0]) |-> !p5_pin_oe[0])
        else $error("timer pin not tristated");
    // port 2 never drives a pin in analog control mode
    p2_ctl_quiet_a: assert property (
        @(posedge clock) disable iff (srst)
        (p2_pin_oe & $past(port2_ctl)) == 8'h00)
        else $error("port 2 drove a control pin");
    // timer output replaces the latch on a port 1 control pin
    p1_timer_drive_a: assert property (
        @(posedge clock) disable iff (srst)
        $past(port1_ctl[0]) && $past(timer_ch2_oe[0]) && !$past(q.hiz_a_s2) && !$past(srst)
        |-> p1_pin_oe[0] && p1_pin_out[0] == $past(timer_ch2_out[0]))
        else $error("timer output missing on port 1 bit 0");
    // tool data owns port 4 bit 0 in programming mode
    tool_data_a: assert property (
        @(posedge clock) disable iff (srst)
        $past(q.fl_s2) && $past(tool_data_oe) && !$past(srst)
        |-> p4_pin_oe[0] && p4_pin_out[0] == $past(tool_data_out))
        else $error("tool data not on port 4 bit 0");
endmodule

/* File: tb/pad_model.sv */
// Purpose: board, pull-up and tool side of a group of pads
// Assumes: ext_en marks a pad that the board or tool drives
// Notes: an undriven pad without pull-up toggles every cycle
module pad_model
#(
    parameter int W = 4
)
(
    input wire logic clock,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pin_pu,
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] level
);
    timeunit 1ns;
    timeprecision 1ns;
    // wandering level of a floating pad
    logic [W-1:0] float_q = '0;
    // floating pads change each cycle so nothing settles by luck
    always_ff @(posedge clock)
    begin
        float_q <= ~float_q;
    end
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (pin_oe[i])
                level[i] = pin_out[i];
            else if (ext_en[i])
                level[i] = ext_val[i];
            else if (pin_pu[i])
                level[i] = 1'b1;
            else
                level[i] = float_q[i];
        end
    end
endmodule

/* File: tb/port_pin_function_mux_test.sv */
// Purpose: self-checking bench for the port pin function mux
// Assumes: pads resolved by pad_model, board drives inputs
// Notes: inputs change 1 ns after the rising edge
module port_pin_function_mux_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, srst = 1'b1;
    logic [3:0] port1_direction_reg = 4'hF, port1_pullup_reg = 4'h0, port1_ctl = 4'h0, port1_latch = 4'h0;
    logic [3:0] timer_ch2_out = 4'h0, timer_ch2_oe = 4'h0, b1_val = 4'h0, b1_en = 4'hF;
    logic [7:0] b2_val = 8'h00, b2_en = 8'hFF, b2_pu = 8'h00;
    logic [1:0] b4_val = 2'h1, b4_en = 2'h3;
    logic [7:0] port2_direction_reg = 8'hFF, port2_ctl = 8'h00, port2_latch = 8'h00;
    logic [2:0] port3_direction_reg = 3'h7, port3_pullup_reg = 3'h0, port3_ctl = 3'h0, port3_latch = 3'h0;
    logic [2:0] port3_open_drain_sel = 3'h0, port5_direction_reg = 3'h7, port5_pullup_reg = 3'h0;
    logic [2:0] port5_ctl = 3'h0, port5_latch = 3'h0, b3_val = 3'h0, b5_val = 3'h0, b3_en = 3'h7, b5_en = 3'h7;
    logic [1:0] port3_input_buffer_sel = 2'h0, port4_direction_reg = 2'h3, port4_pullup_reg = 2'h0;
    logic [1:0] port4_ctl = 2'h0, port4_latch = 2'h0, timer_ch6_out = 2'h0, timer_ch6_oe = 2'h0;
    logic [1:0] irq_edge_sel_a = 2'h0, irq_edge_sel_b = 2'h0;
    logic timer_ch11_out = 1'b0, csi_data_out = 1'b0, csi_clock_out = 1'b0, csi_clock_oe = 1'b0;
    logic uart_b_transmit = 1'b0, uart_b_sel = 1'b0, simple_i2c_data_out = 1'b0, simple_i2c_clock_out = 1'b0;
    logic i2c_sel = 1'b0, timer_ch11_sel = 1'b0, debug_enable_option_bit = 1'b0, debug_active = 1'b0;
    logic debug_two_line = 1'b0, tool_data_out = 1'b0, tool_data_oe = 1'b0, debug_clock_out = 1'b0;
    logic timer_hiz_ctrl_in_a = 1'b0, timer_hiz_ctrl_in_b = 1'b0, flash_prog_mode_pin = 1'b0;
    logic [3:0] p1_pin_in, p1_pin_out, p1_pin_oe, p1_pin_pu, timer_ch2_ext_in, port1_read;
    logic [7:0] p2_pin_in, p2_pin_out, p2_pin_oe, p2_analog_en, port2_read;
    logic [2:0] p3_pin_in, p3_pin_out, p3_pin_oe, p3_pin_pu, p5_pin_in, p5_pin_out, p5_pin_oe, p5_pin_pu;
    logic [2:0] port3_read, port5_read;
    logic [1:0] p3_ttl_en, p4_pin_in, p4_pin_out, p4_pin_oe, p4_pin_pu, timer_ch6_ext_in, port4_read;
    logic timer_ch9_ext_in, csi_data_in, csi_clock_in, uart_b_receive, simple_i2c_data_in;
    logic simple_i2c_clock_in, ext_irq_in_a, ext_irq_in_b, flash_prog_mode;
    int fails = 0, checks_done = 0, irq_a_n = 0, irq_b_n = 0, base_a = 0, base_b = 0;
    port_pin_function_mux u_dut
    (
        .clock, .srst, .port1_direction_reg, .port1_pullup_reg, .port1_ctl, .port1_latch,
        .port2_direction_reg, .port2_ctl, .port2_latch, .port3_direction_reg, .port3_pullup_reg,
        .port3_ctl, .port3_latch, .port3_input_buffer_sel, .port3_open_drain_sel, .port4_direction_reg,
        .port4_pullup_reg, .port4_ctl, .port4_latch, .port5_direction_reg, .port5_pullup_reg, .port5_ctl,
        .port5_latch, .timer_ch2_out, .timer_ch2_oe, .timer_ch6_out, .timer_ch6_oe, .timer_ch11_out,
        .csi_data_out, .csi_clock_out, .csi_clock_oe, .uart_b_transmit, .uart_b_sel, .simple_i2c_data_out,
        .simple_i2c_clock_out, .i2c_sel, .timer_ch11_sel, .irq_edge_sel_a, .irq_edge_sel_b,
        .debug_enable_option_bit, .debug_active, .debug_two_line, .tool_data_out, .tool_data_oe,
        .debug_clock_out, .timer_hiz_ctrl_in_a, .timer_hiz_ctrl_in_b, .flash_prog_mode_pin, .p1_pin_in,
        .p2_pin_in, .p3_pin_in, .p4_pin_in, .p5_pin_in, .p1_pin_out, .p1_pin_oe, .p1_pin_pu, .p2_pin_out,
        .p2_pin_oe, .p2_analog_en, .p3_pin_out, .p3_pin_oe, .p3_pin_pu, .p3_ttl_en, .p4_pin_out, .p4_pin_oe,
        .p4_pin_pu, .p5_pin_out, .p5_pin_oe, .p5_pin_pu, .timer_ch2_ext_in, .timer_ch6_ext_in,
        .timer_ch9_ext_in, .csi_data_in, .csi_clock_in, .uart_b_receive, .simple_i2c_data_in,
        .simple_i2c_clock_in, .ext_irq_in_a, .ext_irq_in_b, .flash_prog_mode, .port2_read, .port1_read,
        .port3_read, .port4_read, .port5_read
    );
    // board side of each port, every pad held by the board unless the chip drives
    pad_model #(.W(4)) u_pad1 (.clock, .pin_out(p1_pin_out), .pin_oe(p1_pin_oe), .pin_pu(p1_pin_pu),
        .ext_val(b1_val), .ext_en(b1_en), .level(p1_pin_in));
    pad_model #(.W(8)) u_pad2 (.clock, .pin_out(p2_pin_out), .pin_oe(p2_pin_oe), .pin_pu(b2_pu),
        .ext_val(b2_val), .ext_en(b2_en), .level(p2_pin_in));
    pad_model #(.W(3)) u_pad3 (.clock, .pin_out(p3_pin_out), .pin_oe(p3_pin_oe), .pin_pu(p3_pin_pu),
        .ext_val(b3_val), .ext_en(b3_en), .level(p3_pin_in));
    // tool data line held high by the board
    pad_model #(.W(2)) u_pad4 (.clock, .pin_out(p4_pin_out), .pin_oe(p4_pin_oe), .pin_pu(p4_pin_pu),
        .ext_val(b4_val), .ext_en(b4_en), .level(p4_pin_in));
    pad_model #(.W(3)) u_pad5 (.clock, .pin_out(p5_pin_out), .pin_oe(p5_pin_oe), .pin_pu(p5_pin_pu),
        .ext_val(b5_val), .ext_en(b5_en), .level(p5_pin_in));
    // 50 ns clock
    initial
    begin
        forever #25 clock = ~clock;
    end
    // count interrupt pulses on the falling edge, away from their launch
    always @(negedge clock)
    begin
        irq_a_n += int'(ext_irq_in_a === 1'b1);
        irq_b_n += int'(ext_irq_in_b === 1'b1);
    end
    // wait n edges, then step off the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // compare one value
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (3000) @(posedge clock);
        fails++;
        stop_test();
    end
    // main sequence
    initial
    begin
        step(20);
        srst = 1'b0;
        step(2);
        chk("p2 analog", p2_analog_en, 8'h00);
        chk("p2 oe", p2_pin_oe, 8'h00);
        port1_direction_reg = 4'h0;
        port1_latch = 4'hA;
        step(2);
        chk("p1 oe", p1_pin_oe, 4'hF);
        chk("p1 out", p1_pin_out, 4'hA);
        port1_direction_reg = 4'hF;
        port1_pullup_reg = 4'h5;
        b1_val = 4'h9;
        // board lets go of bits 0 and 2, the pull-ups hold them high
        b1_en = 4'hA;
        step(5);
        chk("p1 pu", p1_pin_pu, 4'h5);
        chk("p1 read", port1_read, 4'hD);
        port1_ctl = 4'hF;
        b1_en = 4'hF;
        step(5);
        chk("t2 in", timer_ch2_ext_in, 4'h9);
        port1_ctl = 4'h3;
        port1_direction_reg = 4'h0;
        port1_latch = 4'hC;
        timer_ch2_oe = 4'h1;
        timer_ch2_out = 4'hF;
        step(2);
        chk("p1 mix oe", p1_pin_oe, 4'hD);
        chk("p1 mix out", p1_pin_out & p1_pin_oe, 4'hD);
        timer_hiz_ctrl_in_a = 1'b1;
        step(5);
        chk("p1 hiz", p1_pin_oe, 4'hC);
        port2_direction_reg = 8'h00;
        port2_latch = 8'h3C;
        step(2);
        chk("p2 out", p2_pin_out, 8'h3C);
        port2_ctl = 8'hF0;
        step(2);
        chk("p2 analog", p2_analog_en, 8'hF0);
        chk("p2 oe", p2_pin_oe, 8'h0F);
        b2_val = 8'hA5;
        step(4);
        chk("p2 read", port2_read, 8'hAC);
        port3_direction_reg = 3'h0;
        port3_latch = 3'h5;
        port3_open_drain_sel = 3'h7;
        port3_input_buffer_sel = 2'h2;
        step(2);
        chk("p3 od", p3_pin_oe, 3'h2);
        chk("p3 ttl", p3_ttl_en, 2'h2);
        // software clears open drain before port use
        port3_open_drain_sel = 3'h0;
        port3_ctl = 3'h3;
        uart_b_sel = 1'b1;
        uart_b_transmit = 1'b1;
        i2c_sel = 1'b1;
        step(2);
        chk("p3 serial", {p3_pin_oe, p3_pin_out}, 8'h3D);
        timer_ch11_sel = 1'b1;
        step(2);
        chk("p3 t11", p3_pin_out, 3'h4);
        timer_hiz_ctrl_in_a = 1'b0;
        timer_hiz_ctrl_in_b = 1'b1;
        step(5);
        chk("p3 t11 oe", p3_pin_oe, 3'h7);
        timer_hiz_ctrl_in_a = 1'b1;
        step(5);
        chk("p3 t11 hiz", p3_pin_oe, 3'h6);
        port3_direction_reg = 3'h7;
        port3_ctl = 3'h6;
        // bit 0 left to its pull-up
        port3_pullup_reg = 3'h7;
        b3_en = 3'h6;
        uart_b_sel = 1'b0;
        i2c_sel = 1'b0;
        for (int m = 1; m < 4; m++)
        begin
            irq_edge_sel_a = 2'(m);
            irq_edge_sel_b = 2'(m);
            step(6);
            base_a = irq_a_n;
            base_b = irq_b_n;
            b3_val = 3'h6;
            step(8);
            chk("p3 ins", {csi_data_in, uart_b_receive, simple_i2c_data_in, timer_ch9_ext_in,
                csi_clock_in, simple_i2c_clock_in}, 8'h3F);
            chk("p3 read", port3_read, 8'h07);
            chk("p3 pu", p3_pin_pu, 8'h01);
            b3_val = 3'h0;
            step(8);
            chk("irq a", 8'(irq_a_n - base_a), (m == 3) ? 8'h02 : 8'h01);
            chk("irq b", 8'(irq_b_n - base_b), (m == 3) ? 8'h02 : 8'h01);
        end
        port4_direction_reg = 2'h0;
        port4_latch = 2'h3;
        step(2);
        chk("p4 port", {p4_pin_oe, p4_pin_out}, 8'h0F);
        debug_enable_option_bit = 1'b1;
        debug_active = 1'b1;
        tool_data_oe = 1'b1;
        step(2);
        chk("p4 one line", {p4_pin_oe, p4_pin_out}, 8'h0E);
        debug_two_line = 1'b1;
        debug_clock_out = 1'b1;
        port4_latch = 2'h0;
        step(2);
        chk("p4 two line", {p4_pin_oe, p4_pin_out}, 8'h0E);
        debug_clock_out = 1'b0;
        step(2);
        chk("p4 clk low", {p4_pin_oe, p4_pin_out}, 8'h0C);
        debug_active = 1'b0;
        flash_prog_mode_pin = 1'b1;
        tool_data_out = 1'b1;
        step(6);
        chk("flash", {flash_prog_mode, p4_pin_out[0]}, 8'h03);
        port4_direction_reg = 2'h3;
        port4_pullup_reg = 2'h2;
        step(5);
        chk("p4 pu", p4_pin_pu, 8'h02);
        chk("p4 read", port4_read, 8'h01);
        port5_direction_reg = 3'h0;
        port5_ctl = 3'h3;
        port5_latch = 3'h4;
        timer_ch6_oe = 2'h3;
        timer_ch6_out = 2'h1;
        timer_hiz_ctrl_in_b = 1'b0;
        step(5);
        chk("p5 timer", {p5_pin_oe, p5_pin_out}, 8'h3D);
        timer_hiz_ctrl_in_b = 1'b1;
        step(5);
        chk("p5 hiz", p5_pin_oe, 3'h4);
        port5_direction_reg = 3'h7;
        port5_pullup_reg = 3'h7;
        b5_val = 3'h3;
        // board lets go of bit 2, its pull-up holds it high
        b5_en = 3'h3;
        step(5);
        chk("t6 in", {timer_ch6_ext_in, 1'b0, port5_read}, 8'h37);
        // pull-up only on the port-mode input bit
        chk("p5 pu", p5_pin_pu, 3'h4);
        stop_test();
    end
endmodule
